// File: hdl/can_gc_pkg.sv
// Purpose: shared constants for the CAN global control and block transmit logic
// Assumes: AXI4-Lite byte address is four times the register index
// Notes: indices are kept as printed, one aligned 32-bit word each
package can_gc_pkg;
  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;
  localparam logic [IDX_W-1:0] IDX_ENGINE_STAT = 16'hFF60;
  localparam logic [IDX_W-1:0] IDX_GLOBAL_CTRL = 16'hFF64;
  localparam logic [IDX_W-1:0] IDX_ABT_CTRL = 16'hFF66;
  localparam logic [IDX_W-1:0] IDX_CLK_SEL = 16'hFF6E;
  localparam logic [IDX_W-1:0] IDX_ABT_DELAY = 16'hFF6F;
  // set half of a set/clear word sits one byte above the clear half
  localparam int SET_OFS = 8;
  localparam int GOM_POS = 0;
  localparam int FORCED_SHUTDOWN_ENABLE_POS = 1;
  localparam int RUN_POS = 0;
  localparam int CLR_POS = 1;
  localparam int SEL_W = 4;
  localparam logic [SEL_W-1:0] RST_CLK_SEL = 4'hF;
  localparam logic [SEL_W-1:0] RST_ABT_DELAY = 4'h0;
  localparam logic [15:0] RST_ABT_CTRL = 16'h0000;
  localparam logic [3:0] GAP_EXP_OFS = 4'h4;
  localparam logic [3:0] GAP_CODE_MAX = 4'h8;
  localparam int GAP_CNT_W = 13;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ENG_IDLE, ENG_SEND, ENG_GAP} eng_state_t;
endpackage

// File: hdl/can_clk_prescaler.sv
// Purpose: module system clock enable, supplied clock divided by select plus one
// Assumes: div_sel comes from a register on the same clock
// Notes: tick is a one-cycle registered pulse
`timescale 1ns/1ps
module can_clk_prescaler #(
  parameter int SEL_W = 4
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [SEL_W-1:0] div_sel, // divide by div_sel plus one
  output logic tick // one pulse per divided period
);
  typedef struct packed {
    logic [SEL_W-1:0] cnt;
    logic tick;
  } pre_t;
  pre_t s_reg, s_next;
  logic [SEL_W:0] since_reg;
  logic steady_reg;
  logic [SEL_W-1:0] sel_reg;

  if (SEL_W < 1) begin : g_chk
    $error("prescaler select too narrow");
  end

  always_comb begin
    s_next = s_reg;
    // >= rather than == so a smaller select mid-count cannot stall
    s_next.tick = (s_reg.cnt >= div_sel);
    s_next.cnt = s_next.tick ? '0 : s_reg.cnt + 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

  // helper for checking the period only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_reg <= '0;
      steady_reg <= 1'b0;
      sel_reg <= '0;
    end else begin
      sel_reg <= div_sel;
      since_reg <= tick ? '0 : since_reg + 1'b1;
      steady_reg <= (tick || steady_reg) && (div_sel == sel_reg);
    end
  end

  presc_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && steady_reg && $stable(div_sel) |-> since_reg == {1'b0, div_sel})
    else $error("prescaler period differs from select plus one");
endmodule

// File: hdl/can_gap_timer.sv
// Purpose: gap between automatically sent frames, in data bit times
// Assumes: dbt_tick pulses once per data bit time
// Notes: prohibited codes give no gap
`timescale 1ns/1ps
module can_gap_timer #(
  parameter int CNT_W = 13
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic start, // load gap from code
  input wire logic [3:0] code, // gap code
  input wire logic dbt_tick, // one data bit time elapsed
  output logic busy // gap still running
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } gap_t;
  gap_t s_reg, s_next;

  if (CNT_W < can_gc_pkg::GAP_CNT_W) begin : g_chk
    $error("gap counter cannot hold the longest gap");
  end

  always_comb begin
    s_next = s_reg;
    if (start) begin
      if (code == 4'h0 || code > can_gc_pkg::GAP_CODE_MAX) begin
        s_next.cnt = '0;
      end else begin
        s_next.cnt = CNT_W'(1) << (code + can_gc_pkg::GAP_EXP_OFS);
      end
    end else if (dbt_tick && s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy = (s_reg.cnt != '0);

  gap_min_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start && code == 4'h1 |=> s_reg.cnt == CNT_W'(32))
    else $error("code one does not give 32 bit times");
  gap_max_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start && code == 4'h8 |=> s_reg.cnt == CNT_W'(4096))
    else $error("code eight does not give 4096 bit times");
  gap_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start && code == 4'h0 |=> !busy)
    else $error("code zero starts a gap");
endmodule

// File: hdl/can_global_ctrl_auto_block_tx.sv
// Purpose: CAN global enable, forced shutdown, clock prescale and block transmit engine
// Assumes: protocol engine status inputs are on aclk; AXI4-Lite register access
// Notes: block buffers are 0 to 7; one write or one read is served per cycle
// Functional notes
// - clearing global enable works only in init mode or right after shutdown arm
// - set-shutdown bit at 1 arms forced shutdown; 0 leaves it alone
// - global enable: set alone sets, clear alone clears, else no change
// - module clock is supplied clock divided by select plus one
// - engine clear status reads 1 while clearing, drops by itself when done
// - run bit: set alone starts, clear alone stops, else no change
// - run bit reads 1 while block transmit executes, 0 when stopped
// - after a clear, the next start begins at buffer 0
// - first block frame may wait for reception or non-block sending
// - stop lets the frame on the bus finish, then aborts; a stop written in the cycle that frame ends sends one more frame first
// - gap code 0 gives none, 1 to 8 give 2^(code+4) bit times
// - gap applies between block frames only in normal mode with block
// - any other access after shutdown arm drops the arm
// - global enable low disables the module, high enables it
`timescale 1ns/1ps
module can_global_ctrl_auto_block_tx (
  input wire logic aclk, // clock, 40 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [17:0] awaddr, // write byte address
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte enables
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [17:0] araddr, // read byte address
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  input wire logic init_mode, // module is in initialization mode
  input wire logic transmit_in_progress, // a frame is being sent
  input wire logic rx_active, // a frame is being received
  input wire logic nonblock_tx_busy, // buffers 8 to 15 have a request
  input wire logic frame_done, // pulse: block frame ended, good or not
  input wire logic dbt_tick, // pulse: one data bit time
  output logic module_enable, // module may operate
  output logic forced_shutdown, // pulse: forced shutdown requested
  output logic module_clk_tick, // module system clock enable pulse
  output logic block_tx_req, // send block buffer block_tx_buf
  output logic [2:0] block_tx_buf, // block buffer to send
  output logic block_gap_active // gap between block frames runs
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [15:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic global_operation_enable;
    logic forced_shutdown_enable;
    logic forced_shutdown_enable_fresh;
    logic shut;
    logic [3:0] clk_sel;
    logic [3:0] gap_code;
    logic run;
    logic stop_pend;
    logic clr_busy;
    logic [2:0] buf_idx;
    can_gc_pkg::eng_state_t eng;
  } state_t;
  state_t s_reg, s_next;

  logic wr_do;
  logic rd_do;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [15:0] ridx;
  logic is_gctrl;
  logic is_abt;
  logic gom_set;
  logic gom_clr;
  logic active;
  logic gap_start;
  logic gap_busy;
  logic [31:0] rd_word;
  logic rd_ok;

  can_clk_prescaler #(
    .SEL_W(can_gc_pkg::SEL_W)
  ) u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .div_sel(s_reg.clk_sel),
    .tick(module_clk_tick)
  );

  can_gap_timer #(
    .CNT_W(can_gc_pkg::GAP_CNT_W)
  ) u_gap (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(gap_start),
    .code(s_reg.gap_code),
    .dbt_tick(dbt_tick),
    .busy(gap_busy)
  );

  // write waits for both halves; it beats a read in the same cycle
  assign wr_do = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
  assign rd_do = arvalid && !s_reg.rvalid && !wr_do;
  assign awready = !s_reg.aw_got && !s_reg.bvalid;
  assign wready = !s_reg.w_got && !s_reg.bvalid;
  assign arready = !s_reg.rvalid && !wr_do;
  // unstrobed lanes count as zero, so they neither set nor clear
  assign lo = s_reg.wstb[0] ? s_reg.wdat[7:0] : 8'h00;
  assign hi = s_reg.wstb[1] ? s_reg.wdat[15:8] : 8'h00;
  assign is_gctrl = (s_reg.waddr == can_gc_pkg::IDX_GLOBAL_CTRL);
  assign is_abt = (s_reg.waddr == can_gc_pkg::IDX_ABT_CTRL);
  assign gom_set = hi[can_gc_pkg::GOM_POS] && !lo[can_gc_pkg::GOM_POS];
  assign gom_clr = !hi[can_gc_pkg::GOM_POS] && lo[can_gc_pkg::GOM_POS];
  assign active = s_reg.global_operation_enable && !init_mode;
  assign ridx = araddr[17:2];

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (ridx == can_gc_pkg::IDX_GLOBAL_CTRL) begin
      rd_word[can_gc_pkg::FORCED_SHUTDOWN_ENABLE_POS] = s_reg.forced_shutdown_enable;
      rd_word[can_gc_pkg::GOM_POS] = s_reg.global_operation_enable;
    end else if (ridx == can_gc_pkg::IDX_ABT_CTRL) begin
      rd_word[can_gc_pkg::CLR_POS] = s_reg.clr_busy;
      rd_word[can_gc_pkg::RUN_POS] = s_reg.run;
    end else if (ridx == can_gc_pkg::IDX_CLK_SEL) begin
      rd_word[3:0] = s_reg.clk_sel;
    end else if (ridx == can_gc_pkg::IDX_ABT_DELAY) begin
      rd_word[3:0] = s_reg.gap_code;
    end else if (ridx == can_gc_pkg::IDX_ENGINE_STAT) begin
      rd_word[2:0] = s_reg.buf_idx;
      rd_word[3] = (s_reg.eng == can_gc_pkg::ENG_SEND);
      rd_word[4] = (s_reg.eng == can_gc_pkg::ENG_GAP);
      rd_word[5] = s_reg.stop_pend;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.shut = 1'b0;
    gap_start = 1'b0;
    // bus handshakes
    if (awvalid && awready) begin
      s_next.aw_got = 1'b1;
      s_next.waddr = awaddr[17:2];
    end
    if (wvalid && wready) begin
      s_next.w_got = 1'b1;
      s_next.wdat = wdata;
      s_next.wstb = wstrb;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    if (rd_do) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_word;
      s_next.rresp = rd_ok ? can_gc_pkg::RESP_OKAY : can_gc_pkg::RESP_SLVERR;
    end
    // the shutdown arm lasts for exactly one following access
    if (wr_do || rd_do) begin
      s_next.forced_shutdown_enable_fresh = 1'b0;
    end
    if (s_reg.forced_shutdown_enable_fresh && (rd_do || (wr_do && !(is_gctrl && gom_clr)))) begin
      s_next.forced_shutdown_enable = 1'b0;
    end
    // block transmit engine
    unique case (s_reg.eng)
      can_gc_pkg::ENG_IDLE: begin
        if (s_reg.clr_busy) begin
          s_next.buf_idx = 3'h0;
          s_next.clr_busy = 1'b0;
        end else if (s_reg.run && active && !rx_active && !nonblock_tx_busy
                     && !transmit_in_progress) begin
          s_next.eng = can_gc_pkg::ENG_SEND;
        end
      end
      can_gc_pkg::ENG_SEND: begin
        if (!s_reg.global_operation_enable) begin
          // forced shutdown does not wait for the frame
          s_next.eng = can_gc_pkg::ENG_IDLE;
          s_next.run = 1'b0;
          s_next.stop_pend = 1'b0;
        end else if (frame_done) begin
          s_next.buf_idx = s_reg.buf_idx + 3'h1;
          if (s_reg.stop_pend) begin
            s_next.eng = can_gc_pkg::ENG_IDLE;
            s_next.run = 1'b0;
            s_next.stop_pend = 1'b0;
          end else begin
            s_next.eng = can_gc_pkg::ENG_GAP;
            gap_start = 1'b1;
          end
        end
      end
      can_gc_pkg::ENG_GAP: begin
        if (!s_reg.run || !active || !gap_busy) begin
          s_next.eng = can_gc_pkg::ENG_IDLE;
        end
      end
    endcase
    // register writes, after the engine so software wins a tie
    if (wr_do) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = can_gc_pkg::RESP_OKAY;
      if (is_gctrl) begin
        if (gom_set) begin
          s_next.global_operation_enable = 1'b1;
        end else if (gom_clr && (init_mode || s_reg.forced_shutdown_enable_fresh)) begin
          s_next.global_operation_enable = 1'b0;
          s_next.shut = s_reg.forced_shutdown_enable_fresh;
          s_next.forced_shutdown_enable = 1'b0;
        end
        if (hi[can_gc_pkg::FORCED_SHUTDOWN_ENABLE_POS]) begin
          s_next.forced_shutdown_enable = 1'b1;
          s_next.forced_shutdown_enable_fresh = 1'b1;
        end
      end else if (is_abt) begin
        if (hi[can_gc_pkg::RUN_POS] && !lo[can_gc_pkg::RUN_POS]) begin
          s_next.run = 1'b1;
          s_next.stop_pend = 1'b0;
        end else if (!hi[can_gc_pkg::RUN_POS] && lo[can_gc_pkg::RUN_POS]) begin
          if (s_reg.eng == can_gc_pkg::ENG_SEND) begin
            s_next.stop_pend = 1'b1;
          end else begin
            s_next.run = 1'b0;
            // a start picked up in this same idle cycle is withdrawn too
            if (s_reg.eng == can_gc_pkg::ENG_IDLE) begin
              s_next.eng = can_gc_pkg::ENG_IDLE;
            end
          end
        end
        if (hi[can_gc_pkg::CLR_POS]) begin
          s_next.clr_busy = 1'b1;
        end
      end else if (s_reg.waddr == can_gc_pkg::IDX_CLK_SEL) begin
        if (s_reg.wstb[0]) begin
          s_next.clk_sel = lo[3:0];
        end
      end else if (s_reg.waddr == can_gc_pkg::IDX_ABT_DELAY) begin
        if (s_reg.wstb[0]) begin
          s_next.gap_code = lo[3:0];
        end
      end else if (s_reg.waddr != can_gc_pkg::IDX_ENGINE_STAT) begin
        s_next.bresp = can_gc_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.clk_sel <= can_gc_pkg::RST_CLK_SEL;
      s_reg.gap_code <= can_gc_pkg::RST_ABT_DELAY;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign module_enable = s_reg.global_operation_enable;
  assign forced_shutdown = s_reg.shut;
  assign block_tx_req = (s_reg.eng == can_gc_pkg::ENG_SEND);
  assign block_tx_buf = s_reg.buf_idx;
  assign block_gap_active = (s_reg.eng == can_gc_pkg::ENG_GAP);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  gom_guard_a: assert property (
    wr_do && is_gctrl && gom_clr && !init_mode && !s_reg.forced_shutdown_enable_fresh && s_reg.global_operation_enable
    |=> module_enable)
    else $error("global enable cleared outside init mode");
  forced_shutdown_enable_set_a: assert property (
    wr_do && is_gctrl && hi[can_gc_pkg::FORCED_SHUTDOWN_ENABLE_POS] |=> s_reg.forced_shutdown_enable && s_reg.forced_shutdown_enable_fresh)
    else $error("shutdown arm not set");
  gom_set_a: assert property (
    wr_do && is_gctrl && gom_set |=> module_enable)
    else $error("global enable not set");
  clr_done_a: assert property (
    s_reg.clr_busy && s_reg.eng == can_gc_pkg::ENG_IDLE && !(wr_do && is_abt)
    |=> !s_reg.clr_busy && block_tx_buf == 3'h0)
    else $error("engine clear did not finish at buffer 0");
  run_start_a: assert property (
    wr_do && is_abt && hi[0] && !lo[0] |=> s_reg.run)
    else $error("start request ignored");
  stop_idle_a: assert property (
    wr_do && is_abt && !hi[0] && lo[0] && !block_tx_req |=> !s_reg.run && !block_tx_req)
    else $error("stop request left block transmit running");
  stop_finish_a: assert property (
    block_tx_req && s_reg.stop_pend && !frame_done && s_reg.global_operation_enable |=> block_tx_req)
    else $error("stop aborted the frame on the bus");
  gap_hold_a: assert property (
    block_gap_active && gap_busy && s_reg.run && active |=> block_gap_active)
    else $error("gap cut short");
  forced_shutdown_enable_void_a: assert property (
    s_reg.forced_shutdown_enable_fresh && rd_do |=> !s_reg.forced_shutdown_enable ##1 !forced_shutdown)
    else $error("shutdown arm survived another access");
  enable_gate_a: assert property (
    s_reg.eng == can_gc_pkg::ENG_IDLE && !module_enable |=> !block_tx_req)
    else $error("block transmit started while disabled");
  abt_read_a: assert property (
    rd_do && ridx == can_gc_pkg::IDX_ABT_CTRL
    |=> rdata == {30'h0, $past(s_reg.clr_busy), $past(s_reg.run)})
    else $error("control read shows more than status");

  shutdown_c: cover property (forced_shutdown);
  gap_c: cover property (block_gap_active ##2 block_tx_req);
  clear_c: cover property (s_reg.clr_busy ##1 !s_reg.clr_busy);
  stop_c: cover property (block_tx_req && s_reg.stop_pend ##1 !s_reg.run);
endmodule

// File: bench/can_node_model.sv
// Purpose: far-side engine and bus stand-in for the block transmit link
// Assumes: block_tx_req holds until the edge that samples frame_done
// Notes: slow stretches each frame; dbt_tick pulses every other cycle
`timescale 1ns/1ps
module can_node_model (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic slow, // long frames when high
  input wire logic block_tx_req, // engine asks for a frame
  output logic frame_done, // pulse: frame ended
  output logic dbt_tick, // pulse: one data bit time
  output logic transmit_in_progress // frame on the bus
);
  int len;
  logic done_seen;
  // status only shows a frame actually on the bus
  assign transmit_in_progress = block_tx_req && !done_seen;
  always @(posedge aclk) begin
    if (!aresetn) begin
      len <= 0;
      done_seen <= 1'b0;
      frame_done <= 1'b0;
      dbt_tick <= 1'b0;
    end else begin
      dbt_tick <= !dbt_tick;
      frame_done <= 1'b0;
      if (block_tx_req !== 1'b1) begin
        len <= 0;
        done_seen <= 1'b0;
      end else if (!done_seen) begin
        len <= len + 1;
        // one end pulse per frame, so a held request is never acked twice
        if (len >= (slow ? 40 : 3)) begin
          frame_done <= 1'b1;
          done_seen <= 1'b1;
        end
      end
    end
  end
endmodule

// File: bench/can_global_ctrl_auto_block_tx_tb_top.sv
// Purpose: self-checking bench for global control and block transmit
// Assumes: register reads settle through an expectation queue
// Notes: gap length allows one data bit time of slack at its ends
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %0t got %0h exp %0h", $time, (g), (e)); end end
module can_global_ctrl_auto_block_tx_tb_top;
  localparam logic [15:0] gctl = can_gc_pkg::IDX_GLOBAL_CTRL;
  localparam logic [15:0] actl = can_gc_pkg::IDX_ABT_CTRL;
  localparam logic [15:0] csel = can_gc_pkg::IDX_CLK_SEL;
  localparam logic [15:0] gdly = can_gc_pkg::IDX_ABT_DELAY;
  localparam logic [1:0] ok = can_gc_pkg::RESP_OKAY;
  localparam logic [1:0] err = can_gc_pkg::RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic init_mode = 1'b0, rx_active = 1'b0, nonblock_tx_busy = 1'b0, slow = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, transmit_in_progress, frame_done;
  logic dbt_tick, module_enable, forced_shutdown, module_clk_tick, block_tx_req;
  logic block_gap_active, gap_q = 1'b0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] block_tx_buf;
  logic [33:0] expq[$];
  logic [33:0] exp_rd;
  int fail_count = 0, check_count = 0, seed = 32991, fs_count = 0, gap_ticks = 0, last_gap = 0;

  always #12.5 aclk = ~aclk;

  can_global_ctrl_auto_block_tx can_global_ctrl_auto_block_tx_i (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .init_mode(init_mode),
    .transmit_in_progress(transmit_in_progress), .rx_active(rx_active),
    .nonblock_tx_busy(nonblock_tx_busy), .frame_done(frame_done), .dbt_tick(dbt_tick),
    .module_enable(module_enable), .forced_shutdown(forced_shutdown),
    .module_clk_tick(module_clk_tick), .block_tx_req(block_tx_req),
    .block_tx_buf(block_tx_buf), .block_gap_active(block_gap_active));

  can_node_model can_node_model_i (
    .aclk(aclk), .aresetn(aresetn), .slow(slow), .block_tx_req(block_tx_req),
    .frame_done(frame_done), .dbt_tick(dbt_tick), .transmit_in_progress(transmit_in_progress));

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic timeout(input int n);
    if (n > 20000) begin
      fail_count++;
      $display("mismatch %0t wait ran out", $time);
      test_done();
    end
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: sig = block_tx_req;
      1: sig = block_gap_active;
      default: sig = module_clk_tick;
    endcase
  endfunction

  task automatic wait_on(input int s, input logic v);
    int n;
    n = 0;
    while (sig(s) !== v) begin
      @(posedge aclk);
      n++;
      timeout(n);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      timeout(n);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK(bresp, er)
    @(posedge aclk);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    expq.push_back({er, d});
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      timeout(n);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic clk_period(input logic [3:0] sel);
    logic [31:0] d;
    int n;
    d = $random(seed);
    d[3:0] = sel;
    wr(csel, d, ok);
    rd(csel, {28'h0, sel}, ok);
    // first period after a change may be partial, so the second is judged
    repeat (2) begin
      wait_on(2, 1'b1);
      @(posedge aclk);
      n = 1;
      while (module_clk_tick !== 1'b1) begin
        @(posedge aclk);
        n++;
        timeout(n);
      end
    end
    `CHK(n, int'(sel) + 1)
  endtask

  task automatic stop_engine();
    wr(actl, 32'h0001, ok);
    wait_on(0, 1'b0);
    wait_on(1, 1'b0);
    repeat (4) @(posedge aclk);
    rd(actl, 32'h0, ok);
  endtask

  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      if (expq.size() == 0) begin
        fail_count++;
        $display("mismatch %0t unexpected read", $time);
      end else begin
        // pop once, the compare macro names its expectation twice
        exp_rd = expq.pop_front();
        `CHK({rresp, rdata}, exp_rd)
      end
    end
    if (forced_shutdown === 1'b1) fs_count++;
    if (block_gap_active === 1'b1 && dbt_tick === 1'b1) gap_ticks <= gap_ticks + 1;
    if (block_gap_active !== 1'b1 && gap_q) begin
      last_gap <= gap_ticks;
      gap_ticks <= 0;
    end
    gap_q <= block_gap_active;
  end

  initial begin
    int i;
    int exp_gap;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(actl, 32'h0, ok);
    rd(csel, 32'h0000000F, ok);
    rd(gdly, 32'h0, ok);
    rd(gctl, 32'h0, ok);
    rd(16'h0123, 32'h0, err);
    wr(16'h0123, 32'h0100, err);
    wr(can_gc_pkg::IDX_ENGINE_STAT, 32'h00FF, ok);
    $display("test reset done");
    clk_period(4'h0);
    clk_period(4'hF);
    for (i = 0; i < 4; i++) clk_period(4'($random(seed)));
    $display("test prescaler done");
    wr(gctl, 32'h0100, ok);
    `CHK(module_enable, 1'b1)
    wr(gctl, 32'h0101, ok);
    wr(gctl, 32'h0001, ok);
    `CHK(module_enable, 1'b1)
    init_mode <= 1'b1;
    wr(gctl, 32'h0001, ok);
    `CHK(module_enable, 1'b0)
    init_mode <= 1'b0;
    wr(gctl, 32'h0100, ok);
    wr(gctl, 32'h0200, ok);
    wr(gdly, 32'h0, ok);
    rd(gctl, 32'h1, ok);
    wr(gctl, 32'h0001, ok);
    `CHK(module_enable, 1'b1)
    `CHK(fs_count, 0)
    wr(gctl, 32'h0200, ok);
    wr(gctl, 32'h0001, ok);
    `CHK(module_enable, 1'b0)
    `CHK(fs_count, 1)
    rd(gctl, 32'h0, ok);
    wr(gctl, 32'h0100, ok);
    $display("test global done");
    rx_active <= 1'b1;
    `CHK(transmit_in_progress, 1'b0)
    wr(actl, 32'h0100, ok);
    repeat (20) @(posedge aclk);
    `CHK(block_tx_req, 1'b0)
    rd(actl, 32'h1, ok);
    rx_active <= 1'b0;
    nonblock_tx_busy <= 1'b1;
    repeat (20) @(posedge aclk);
    `CHK(block_tx_req, 1'b0)
    nonblock_tx_busy <= 1'b0;
    for (i = 0; i < 10; i++) begin
      wait_on(0, 1'b1);
      `CHK(block_tx_buf, 3'(i))
      wait_on(0, 1'b0);
    end
    wr(actl, 32'h0101, ok);
    rd(actl, 32'h1, ok);
    slow <= 1'b1;
    wait_on(0, 1'b0);
    wait_on(0, 1'b1);
    wr(actl, 32'h0001, ok);
    `CHK(block_tx_req, 1'b1)
    rd(actl, 32'h1, ok);
    stop_engine();
    wr(actl, 32'h0200, ok);
    repeat (20) @(posedge aclk);
    rd(actl, 32'h0, ok);
    slow <= 1'b0;
    wr(actl, 32'h0100, ok);
    wait_on(0, 1'b1);
    `CHK(block_tx_buf, 3'h0)
    stop_engine();
    $display("test engine done");
    for (i = 0; i < 9; i++) begin
      wr(gdly, 32'(i), ok);
      rd(gdly, 32'(i), ok);
      `CHK(transmit_in_progress, 1'b0)
      wr(actl, 32'h0100, ok);
      wait_on(1, 1'b1);
      wait_on(1, 1'b0);
      repeat (2) @(posedge aclk);
      exp_gap = i ? 1 << (i + 4) : 0;
      `CHK((last_gap >= exp_gap - 1) && (last_gap <= exp_gap + 1), 1'b1)
      stop_engine();
    end
    $display("test gap done");
    wr(actl, 32'h0000, ok);
    rd(actl, 32'h0, ok);
    init_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK(block_tx_req, 1'b0)
    test_done();
  end
endmodule
